// File: link_partner_model.sv
// Behavioural link partner driving live physical and data link state.
// Assumes one-cycle commands on clk_sys; training lasts fifteen cycles.
`default_nettype none

module link_partner_model
	import link_slot_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic train_go,
	input wire logic train_bad,
	output phy_state_s phy_state
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			phy_state <= '{SPEED_5G, WIDTH_RST_DN, 1'b0, 1'b0, 1'b0, 1'b0};
			cnt_q <= 4'h0;
		end else if (train_go) begin
			phy_state.training <= 1'b1;
			phy_state.train_failed <= 1'b0;
			phy_state.in_l0 <= 1'b0;
			phy_state.dl_active <= 1'b0;
			cnt_q <= 4'hf;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				phy_state.training <= 1'b0;
				phy_state.train_failed <= train_bad;
				phy_state.in_l0 <= !train_bad;
				phy_state.dl_active <= !train_bad;
				phy_state.speed <= SPEED_2G5;
			end
		end
	end
endmodule

`default_nettype wire

// File: link_slot_pkg.sv
// Package of constants and carrier types for the port link status and slot
// capability register bank.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
`default_nettype none

package link_slot_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_PORT_LINK_STATE = 8'hd0;
	localparam logic [7:0] OFF_SLOT_FEATURE = 8'hd4;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'he0;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'he4;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'he8;

	// Port link state fields (low half is link control)
	localparam int unsigned POS_RETRAIN = 5;
	localparam int unsigned POS_SPEED = 16;
	localparam int unsigned POS_WIDTH = 20;
	localparam int unsigned POS_TRAIN_ERR = 26;
	localparam int unsigned POS_TRAINING = 27;
	localparam int unsigned POS_SLOT_CLK = 28;
	localparam int unsigned POS_DL_ACTIVE = 29;

	// Slot feature description fields
	localparam int unsigned POS_ATTN_BTN = 0;
	localparam int unsigned POS_PWR_CTL = 1;
	localparam int unsigned POS_ATTN_IND = 3;
	localparam int unsigned POS_PWR_IND = 4;
	localparam int unsigned POS_SURPRISE = 5;
	localparam int unsigned POS_HOTPLUG = 6;
	localparam int unsigned POS_SPL_VALUE = 7;
	localparam int unsigned POS_SPL_SCALE = 15;
	localparam int unsigned POS_SLOT_NUM = 19;

	// Speed encodings and reset values
	localparam logic [3:0] SPEED_2G5 = 4'h1;
	localparam logic [3:0] SPEED_5G = 4'h2;
	localparam logic [3:0] SPEED_RST = SPEED_5G;
	localparam logic [5:0] WIDTH_RST_UP = 6'h02;
	localparam logic [5:0] WIDTH_RST_DN = 6'h01;
	localparam logic [7:0] SPL_VALUE_RST = 8'h00;
	localparam logic [1:0] SPL_SCALE_RST = 2'h0;
	localparam logic [12:0] SLOT_NUM_RST = 13'h0000;

	// Interrupt event bits
	localparam int unsigned IRQ_N = 4;
	localparam int unsigned EV_TRAIN_ERR = 0;
	localparam int unsigned EV_DL_CHANGE = 1;
	localparam int unsigned EV_SPL_SENT = 2;
	localparam int unsigned EV_TRAIN_DONE = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Live physical / data link layer state
	typedef struct packed {
		logic [3:0] speed;
		logic [5:0] width;
		logic training;
		logic train_failed;
		logic in_l0;
		logic dl_active;
	} phy_state_s;

	// Default override from SMBus or EEPROM autoload
	typedef struct packed {
		logic valid;
		logic sel_slot;
		logic [31:0] data;
	} cfg_load_s;

	// Set_Slot_Power_Limit message request
	typedef struct packed {
		logic req;
		logic [7:0] value;
		logic [1:0] scale;
	} spl_msg_s;

endpackage

`default_nettype wire

// File: pcie_link_status_slot_caps.sv
// Port link status and slot capability register bank with AXI4-Lite access.
// Assumes live link state and override loads arrive on clk_sys; the slot
// clock strap is an asynchronous pin.
//
// Function
// - Negotiated link rate is a read-only four-bit field, 0001b for 2.5 Gb/s, 0010b for 5 Gb/s, reset 0010b.
// - Negotiated lane count is a read-only six-bit field, resetting to x2 upstream and x1 downstream.
// - Training error flag sets when training fails, clears on reaching L0, resets to zero.
// - Training flag reads one while training is under way, clears when done, resets to zero.
// - Slot clock bit selects independent (0) or platform (1) clock and resets from the strap pin.
// - Link-active bit is one exactly while the data link layer is in DL_Active, reset zero.
// - Capability defaults can be overridden by SMBus writes or EEPROM autoload.
// - Downstream ports carry read-only button, power controller and indicator presence bits, reset zero.
// - Surprise-removal and hot-plug-capable bits are read-only and reset zero.
// - The eight-bit power limit value is writable, resets to 00h, and every write enabling byte lane 0, 1 or 2 sends a limit message.
// - The two-bit power limit scale is writable, resets to 00b, and every write enabling byte lane 0, 1 or 2 sends a limit message.
// - The thirteen-bit physical slot number is read-only and resets to zero.
// - Slot power limit fields exist only on downstream ports.
// - Setting the retrain bit starts retraining on downstream ports; upstream ignores it; it reads zero.
`default_nettype none

module pcie_link_status_slot_caps
	import link_slot_pkg::*;
#(
	parameter bit IS_DOWNSTREAM = 1'b1
) (
	input wire logic clk_sys,
	input wire logic resetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link side
	input wire phy_state_s phy_state,
	input wire logic slot_clock_strap,
	input wire cfg_load_s cfg_load,
	output spl_msg_s spl_msg,
	output logic retrain_req,
	output logic irq
);

	typedef struct packed {
		// Bus slave
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
		// Port link state
		logic [3:0] speed;
		logic [5:0] width;
		logic train_err;
		logic training;
		logic slot_clk;
		logic dl_active;
		// Slot feature description
		logic attn_btn;
		logic pwr_ctl;
		logic attn_ind;
		logic pwr_ind;
		logic surprise;
		logic hotplug;
		logic [7:0] spl_value;
		logic [1:0] spl_scale;
		logic [12:0] slot_num;
		// Outgoing requests
		logic spl_req;
		logic retrain;
		// Interrupts
		logic [IRQ_N-1:0] irq_status;
		logic [IRQ_N-1:0] irq_enable;
	} state_s;

	localparam logic [5:0] WIDTH_RST = IS_DOWNSTREAM ? WIDTH_RST_DN : WIDTH_RST_UP;

	state_s state_q;
	state_s state_d;
	logic strap_level;

	strap_sync #(
		.WIDTH(1)
	) u_strap_sync (
		.clk_sys(clk_sys),
		.async_in(slot_clock_strap),
		.sync_out(strap_level)
	);

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a[ADDR_W-1:2] == off[ADDR_W-1:2];
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return addr_hit(a, OFF_PORT_LINK_STATE) || addr_hit(a, OFF_SLOT_FEATURE) ||
			addr_hit(a, OFF_IRQ_STATUS) || addr_hit(a, OFF_IRQ_CLEAR) ||
			addr_hit(a, OFF_IRQ_ENABLE);
	endfunction

	// Handshake outputs
	assign s_axi_awready = !state_q.aw_held && !state_q.bvalid;
	assign s_axi_wready = !state_q.w_held && !state_q.bvalid;
	assign s_axi_arready = !state_q.rvalid;

	logic [31:0] link_word;
	logic [31:0] slot_word;
	logic [31:0] wmask;
	logic [31:0] slot_wr;
	logic do_write;
	logic [IRQ_N-1:0] ev_set;
	logic [IRQ_N-1:0] ev_clr;

	always_comb begin
		link_word = '0;
		link_word[POS_SPEED +: 4] = state_q.speed;
		link_word[POS_WIDTH +: 6] = state_q.width;
		link_word[POS_TRAIN_ERR] = state_q.train_err;
		link_word[POS_TRAINING] = state_q.training;
		link_word[POS_SLOT_CLK] = state_q.slot_clk;
		link_word[POS_DL_ACTIVE] = state_q.dl_active;
		slot_word = '0;
		if (IS_DOWNSTREAM) begin
			slot_word[POS_ATTN_BTN] = state_q.attn_btn;
			slot_word[POS_PWR_CTL] = state_q.pwr_ctl;
			slot_word[POS_ATTN_IND] = state_q.attn_ind;
			slot_word[POS_PWR_IND] = state_q.pwr_ind;
			slot_word[POS_SURPRISE] = state_q.surprise;
			slot_word[POS_HOTPLUG] = state_q.hotplug;
			slot_word[POS_SPL_VALUE +: 8] = state_q.spl_value;
			slot_word[POS_SPL_SCALE +: 2] = state_q.spl_scale;
			slot_word[POS_SLOT_NUM +: 13] = state_q.slot_num;
		end
	end

	always_comb begin
		state_d = state_q;
		wmask = strb_mask(state_q.wstrb);
		slot_wr = (slot_word & ~wmask) | (state_q.wdata & wmask);
		do_write = state_q.aw_held && state_q.w_held && !state_q.bvalid;
		ev_set = '0;
		ev_clr = '0;
		state_d.spl_req = 1'b0;
		state_d.retrain = 1'b0;

		// Write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			state_d.aw_held = 1'b1;
			state_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_d.w_held = 1'b1;
			state_d.wdata = s_axi_wdata;
			state_d.wstrb = s_axi_wstrb;
		end
		if (state_q.bvalid && s_axi_bready) begin
			state_d.bvalid = 1'b0;
		end

		// Live link state
		state_d.speed = phy_state.speed;
		state_d.width = phy_state.width;
		state_d.training = phy_state.training;
		state_d.dl_active = phy_state.dl_active;
		if (phy_state.train_failed) begin
			state_d.train_err = 1'b1;
		end else if (phy_state.in_l0) begin
			state_d.train_err = 1'b0;
		end
		ev_set[EV_TRAIN_ERR] = phy_state.train_failed && !state_q.train_err;
		ev_set[EV_DL_CHANGE] = phy_state.dl_active != state_q.dl_active;
		ev_set[EV_TRAIN_DONE] = state_q.training && !phy_state.training;

		// Default override load
		if (cfg_load.valid) begin
			if (cfg_load.sel_slot) begin
				state_d.attn_btn = cfg_load.data[POS_ATTN_BTN];
				state_d.pwr_ctl = cfg_load.data[POS_PWR_CTL];
				state_d.attn_ind = cfg_load.data[POS_ATTN_IND];
				state_d.pwr_ind = cfg_load.data[POS_PWR_IND];
				state_d.surprise = cfg_load.data[POS_SURPRISE];
				state_d.hotplug = cfg_load.data[POS_HOTPLUG];
				state_d.spl_value = cfg_load.data[POS_SPL_VALUE +: 8];
				state_d.spl_scale = cfg_load.data[POS_SPL_SCALE +: 2];
				state_d.slot_num = cfg_load.data[POS_SLOT_NUM +: 13];
			end else begin
				state_d.slot_clk = cfg_load.data[POS_SLOT_CLK];
			end
		end

		// Register write, one cycle after address and data are both held
		if (do_write) begin
			state_d.aw_held = 1'b0;
			state_d.w_held = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = addr_mapped(state_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (addr_hit(state_q.aw_addr, OFF_PORT_LINK_STATE)) begin
				if (IS_DOWNSTREAM && state_q.wstrb[0] && state_q.wdata[POS_RETRAIN]) begin
					state_d.retrain = 1'b1;
				end
			end
			if (addr_hit(state_q.aw_addr, OFF_SLOT_FEATURE) && IS_DOWNSTREAM &&
				|state_q.wstrb[2:0]) begin
				state_d.spl_value = slot_wr[POS_SPL_VALUE +: 8];
				state_d.spl_scale = slot_wr[POS_SPL_SCALE +: 2];
				state_d.spl_req = 1'b1;
			end
			if (addr_hit(state_q.aw_addr, OFF_IRQ_CLEAR) && state_q.wstrb[0]) begin
				ev_clr = state_q.wdata[IRQ_N-1:0];
			end
			if (addr_hit(state_q.aw_addr, OFF_IRQ_ENABLE) && state_q.wstrb[0]) begin
				state_d.irq_enable = state_q.wdata[IRQ_N-1:0];
			end
		end
		ev_set[EV_SPL_SENT] = state_d.spl_req;

		// Sticky status: a set in the clearing cycle wins
		state_d.irq_status = (state_q.irq_status & ~ev_clr) | ev_set;

		// Read channel
		if (state_q.rvalid && s_axi_rready) begin
			state_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			state_d.rvalid = 1'b1;
			state_d.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			state_d.rdata = '0;
			if (addr_hit(s_axi_araddr, OFF_PORT_LINK_STATE)) begin
				state_d.rdata = link_word;
			end else if (addr_hit(s_axi_araddr, OFF_SLOT_FEATURE)) begin
				state_d.rdata = slot_word;
			end else if (addr_hit(s_axi_araddr, OFF_IRQ_STATUS)) begin
				state_d.rdata[IRQ_N-1:0] = state_q.irq_status;
			end else if (addr_hit(s_axi_araddr, OFF_IRQ_ENABLE)) begin
				state_d.rdata[IRQ_N-1:0] = state_q.irq_enable;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= '0;
			state_q.speed <= SPEED_RST;
			state_q.width <= WIDTH_RST;
			state_q.slot_clk <= strap_level;
			state_q.spl_value <= SPL_VALUE_RST;
			state_q.spl_scale <= SPL_SCALE_RST;
			state_q.slot_num <= SLOT_NUM_RST;
		end else begin
			state_q <= state_d;
		end
	end

	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_rvalid = state_q.rvalid;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
	assign spl_msg = '{
		req: state_q.spl_req,
		value: state_q.spl_value,
		scale: state_q.spl_scale
	};
	assign retrain_req = state_q.retrain;
	assign irq = |(state_q.irq_status & state_q.irq_enable);

endmodule

`default_nettype wire

// File: slot_caps_checker.sv
// Bus handshake and message timing assertions for the link status register bank.
// Assumes one clk_sys domain and a synchronous active-low resetn.
`default_nettype none

module slot_caps_checker
	import link_slot_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire spl_msg_s spl_msg,
	input wire logic retrain_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	a_msg_pulse: assert property (spl_msg.req |=> !spl_msg.req)
		else $error("limit message longer than one cycle");
	a_msg_with_resp: assert property (spl_msg.req |-> s_axi_bvalid)
		else $error("limit message without write");
	a_retrain_pulse: assert property (retrain_req |-> s_axi_bvalid ##1 !retrain_req)
		else $error("retrain pulse wrong");
endmodule

bind pcie_link_status_slot_caps slot_caps_checker i_slot_caps_checker (.*);

`default_nettype wire

// File: strap_sync.sv
// Two-flop synchroniser for asynchronous level inputs such as straps.
// Assumes the input is quasi-static; no event is carried across.
`default_nettype none

module strap_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_s;

	sync_state_s state_q;
	sync_state_s state_d;

	always_comb begin
		state_d.stage1 = async_in;
		state_d.stage2 = state_q.stage1;
	end

	// No reset: the strap level must reach the second stage while reset is still held
	always_ff @(posedge clk_sys) begin
		state_q <= state_d;
	end

	assign sync_out = state_q.stage2;

endmodule

`default_nettype wire

// File: tb_pcie_link_status_slot_caps.sv
// Self-checking bench for the link status and slot capability register bank.
// Assumes the default downstream build and a 40 MHz clk_sys.
`default_nettype none

module tb_pcie_link_status_slot_caps
	import link_slot_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, irq, retrain_req;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic strap = 1'b1, go = 1'b0, bad = 1'b0;
	cfg_load_s cfg_load = '0;
	phy_state_s phy_state;
	spl_msg_s spl_msg;
	int bad_count = 0, samples_checked = 0, cyc = 0, spl_cnt = 0, rt_cnt = 0;
	logic [9:0] spl_last = 10'h0;
	logic [31:0] rdata_up;
	logic [31:0] up_seen = 32'h0;
	logic retrain_up;
	spl_msg_s spl_msg_up;
	int up_pulses = 0;

	pcie_link_status_slot_caps i_pcie_link_status_slot_caps (
		.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.phy_state(phy_state), .slot_clock_strap(strap), .cfg_load(cfg_load),
		.spl_msg(spl_msg), .retrain_req(retrain_req), .irq(irq)
	);
	link_partner_model i_link_partner_model (
		.clk_sys(clk_sys), .resetn(resetn), .train_go(go), .train_bad(bad),
		.phy_state(phy_state)
	);
	// Upstream build shares the bus inputs; only its read data and pulses are watched
	pcie_link_status_slot_caps #(
		.IS_DOWNSTREAM(1'b0)
	) i_pcie_link_status_slot_caps_up (
		.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
		.s_axi_rdata(rdata_up), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
		.phy_state(phy_state), .slot_clock_strap(strap), .cfg_load(cfg_load),
		.spl_msg(spl_msg_up), .retrain_req(retrain_up), .irq()
	);

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Counts message and retrain pulses; cuts a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (spl_msg.req === 1'b1) begin
			spl_cnt <= spl_cnt + 1;
			spl_last <= {spl_msg.value, spl_msg.scale};
		end
		if (retrain_req === 1'b1)
			rt_cnt <= rt_cnt + 1;
		if (spl_msg_up.req !== 1'b0 || retrain_up !== 1'b0)
			up_pulses <= up_pulses + 1;
		if (cyc == 4000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		up_seen = rdata_up;
		rready <= 1'b0;
		chk($sformatf("rdata %h", a), e, rdata);
		chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic ld(input logic s, input logic [31:0] d);
		@(posedge clk_sys);
		cfg_load <= '{1'b1, s, d};
		@(posedge clk_sys);
		cfg_load.valid <= 1'b0;
	endtask

	task automatic tr(input logic b);
		@(posedge clk_sys);
		go <= 1'b1;
		bad <= b;
		@(posedge clk_sys);
		go <= 1'b0;
	endtask

	task automatic t_reset();
		rd(OFF_PORT_LINK_STATE, 32'h1012_0000, RESP_OKAY);
		rd(OFF_SLOT_FEATURE, 32'h0, RESP_OKAY);
		$display("test reset values done");
	endtask

	task automatic t_retrain();
		wr(OFF_PORT_LINK_STATE, 32'h0000_0020, RESP_OKAY);
		rd(OFF_PORT_LINK_STATE, 32'h1012_0000, RESP_OKAY);
		chk("retrain pulses", 32'd1, rt_cnt);
		$display("test retrain done");
	endtask

	task automatic t_spl_irq();
		wr(OFF_IRQ_ENABLE, 32'h4, RESP_OKAY);
		wr(OFF_SLOT_FEATURE, 32'hfff9_52ff, RESP_OKAY);
		wr(OFF_SLOT_FEATURE, 32'hfff9_52ff, RESP_OKAY);
		rd(OFF_SLOT_FEATURE, 32'h0001_5280, RESP_OKAY);
		chk("limit messages", 32'd2, spl_cnt);
		chk("limit payload", {22'h0, 8'ha5, 2'h2}, {22'h0, spl_last});
		rd(OFF_IRQ_STATUS, 32'h4, RESP_OKAY);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(OFF_IRQ_CLEAR, 32'h4, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(8'hf0, 32'hff, RESP_SLVERR);
		rd(8'hf0, 32'h0, RESP_SLVERR);
		chk("upstream pulses", 32'd0, up_pulses);
		$display("test limit writes and interrupt done");
	endtask

	task automatic t_load();
		ld(1'b1, 32'hfff9_fffb);
		rd(OFF_SLOT_FEATURE, 32'hfff9_fffb, RESP_OKAY);
		chk("limit messages", 32'd2, spl_cnt);
		chk("upstream slot word", 32'h0, up_seen);
		ld(1'b0, 32'h0);
		rd(OFF_PORT_LINK_STATE, 32'h0012_0000, RESP_OKAY);
		$display("test default override done");
	endtask

	task automatic t_train();
		tr(1'b1);
		rd(OFF_PORT_LINK_STATE, 32'h0812_0000, RESP_OKAY);
		repeat (24) @(posedge clk_sys);
		rd(OFF_PORT_LINK_STATE, 32'h0411_0000, RESP_OKAY);
		tr(1'b0);
		rd(OFF_PORT_LINK_STATE, 32'h0c11_0000, RESP_OKAY);
		repeat (24) @(posedge clk_sys);
		rd(OFF_PORT_LINK_STATE, 32'h2011_0000, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 32'hb, RESP_OKAY);
		chk("irq masked", 32'h0, {31'h0, irq});
		$display("test link training done");
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_retrain();
		t_spl_irq();
		t_load();
		t_train();
		close_out();
	end
endmodule

`default_nettype wire
